// >>> design/pas_top.sv
// What this block does
// - a new sample begins on each rising edge of the sample strobe
// - strobe counts high when true input exceeds complement, else low
// - track input while strobe low, freeze it at the low-to-high edge
// - four quantiser stages; result appears five strobe cycles after sampling
// - adjacent stages acquire in opposite strobe phases
// - stage results are aligned and merged before the output buffer
// - format select low inverts top bit for two's complement, high leaves it
// - sample word driven when drive enable low, released when high
// - range flag high when the sample's input lay outside the convertible range
// - each result is a 14-bit parallel word, bit 0 to bit 13
//
// top of the sample output block: strobe edges, hold, stages, format, pins
// assumes all pins but mclk_i and sys_rst_i are asynchronous to mclk_i and the strobe is far slower
`timescale 1ns/1ps
`default_nettype none
module pas_top (
  input  wire logic                       mclk_i,                // system clock
  input  wire logic                       sys_rst_i,             // sync reset, high
  input  wire logic                       sample_strobe_p_i,     // strobe true input
  input  wire logic                       sample_strobe_n_i,     // strobe complement input
  input  wire logic [pas_pkg::IN_W-1:0]   analog_level_i,        // signed input level
  input  wire logic                       top_bit_flip_sel_i,    // format select
  input  wire logic                       output_drive_en_n_i,   // word drive enable, low
  output logic      [pas_pkg::WORD_W-1:0] sample_word_o,         // converted word
  output logic                            sample_word_oe_o,      // word pins driven
  output logic                            data_valid_strobe_o,   // rising edge: word valid
  output logic                            range_exceeded_flag_o  // input out of range
);
  import pas_pkg::*;

  typedef struct packed {
    logic [SYNC_N-1:0]               stp_sync;
    logic [SYNC_N-1:0]               stn_sync;
    logic [SYNC_N-1:0]               fmt_sync;
    logic [SYNC_N-1:0]               oen_sync;
    logic [SYNC_N-1:0][IN_W-1:0]     lvl_sync;
    logic                            strobe_hi;
    logic [WORD_W-1:0]               track;
    logic                            track_ovf;
    logic [WORD_W-1:0]               held;
    logic                            held_ovf;
    logic [POST_DLY-2:0][WORD_W-1:0] code_dly;
    logic [POST_DLY-2:0]             ovf_dly;
    logic [WORD_W-1:0]               word;
    logic                            ovf;
    logic                            dvs;
  } pas_top_t;

  pas_top_t st_ff;
  pas_top_t nxt_st;

  logic              strobe_now;
  logic              rise_ev;
  logic              fall_ev;
  logic signed [IN_W-1:0] lvl;
  logic [WORD_W-1:0] res_w  [STAGE_N+1];
  logic [WORD_W-1:0] code_w [STAGE_N+1];
  logic              ovf_w  [STAGE_N+1];

  // level outside the convertible range
  function automatic logic beyond_range(input logic signed [IN_W-1:0] l);
    return (l < IN_MIN) || (l > IN_MAX);
  endfunction

  // clamp a tracked level into the offset-binary word
  function automatic logic [WORD_W-1:0] clamp_word(input logic signed [IN_W-1:0] l);
    logic [WORD_W-1:0] w;
    if (l < IN_MIN) begin
      w = WORD_RST;
    end else if (l > IN_MAX) begin
      w = '1;
    end else begin
      w = WORD_W'(l + IN_BIAS);
    end
    return w;
  endfunction

  assign strobe_now = st_ff.stp_sync[SYNC_N-1] & ~st_ff.stn_sync[SYNC_N-1];
  assign rise_ev    = strobe_now & ~st_ff.strobe_hi;
  assign fall_ev    = ~strobe_now & st_ff.strobe_hi;
  assign lvl        = st_ff.lvl_sync[SYNC_N-1];

  // held sample feeds the first stage
  assign res_w[0]  = st_ff.held;
  assign code_w[0] = WORD_RST;
  assign ovf_w[0]  = st_ff.held_ovf;

  // even stages take on the falling edge, odd on the rising edge
  generate
    for (genvar gi = 0; gi < STAGE_N; gi++) begin : g_stage
      pas_stage #(
        .BITS(STAGE_BITS[gi])
      ) u_stage (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .capture_i ((gi % 2 == 0) ? fall_ev : rise_ev),
        .res_i     (res_w[gi]),
        .code_i    (code_w[gi]),
        .ovf_i     (ovf_w[gi]),
        .res_o     (res_w[gi+1]),
        .code_o    (code_w[gi+1]),
        .ovf_o     (ovf_w[gi+1])
      );
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    nxt_st.stp_sync  = {st_ff.stp_sync[SYNC_N-2:0], sample_strobe_p_i};
    nxt_st.stn_sync  = {st_ff.stn_sync[SYNC_N-2:0], sample_strobe_n_i};
    nxt_st.fmt_sync  = {st_ff.fmt_sync[SYNC_N-2:0], top_bit_flip_sel_i};
    nxt_st.oen_sync  = {st_ff.oen_sync[SYNC_N-2:0], output_drive_en_n_i};
    nxt_st.lvl_sync  = {st_ff.lvl_sync[SYNC_N-2:0], analog_level_i};
    nxt_st.strobe_hi = strobe_now;
    // follow the input while the strobe is low
    if (!strobe_now) begin
      nxt_st.track_ovf = beyond_range(lvl);
      nxt_st.track     = clamp_word(lvl);
    end
    if (rise_ev) begin
      nxt_st.held     = st_ff.track;
      nxt_st.held_ovf = st_ff.track_ovf;
      // merge aligned stage codes, then two more rises to the pins
      nxt_st.code_dly[0] = code_w[STAGE_N];
      nxt_st.ovf_dly[0]  = ovf_w[STAGE_N];
      nxt_st.code_dly[0][MSB_IDX] = code_w[STAGE_N][MSB_IDX] ^ ~st_ff.fmt_sync[SYNC_N-1];
      for (int i = 1; i < POST_DLY - 1; i++) begin
        nxt_st.code_dly[i] = st_ff.code_dly[i-1];
        nxt_st.ovf_dly[i]  = st_ff.ovf_dly[i-1];
      end
      nxt_st.word = st_ff.code_dly[POST_DLY-2];
      nxt_st.ovf  = st_ff.ovf_dly[POST_DLY-2];
      nxt_st.dvs  = 1'b0;
    end else if (fall_ev) begin
      nxt_st.dvs  = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sample_word_o         = st_ff.word;
  assign sample_word_oe_o      = ~st_ff.oen_sync[SYNC_N-1];
  assign data_valid_strobe_o   = st_ff.dvs;
  assign range_exceeded_flag_o = st_ff.ovf;
endmodule
`default_nettype wire

// >>> design/pas_pkg.sv
// constants for the pipelined converter sample output block
// assumes a single 100 MHz system clock drives all users
package pas_pkg;
  localparam int WORD_W      = 14;              // output word width
  localparam int IN_W        = 16;              // signed input level width
  localparam int STAGE_N     = 4;               // pipelined quantiser stages
  localparam int STAGE_BITS [STAGE_N] = '{4, 4, 3, 3};
  localparam int POST_DLY    = 3;               // strobe rises after last stage
  localparam int LATENCY     = 5;               // strobe cycles sample to word
  localparam int SYNC_N      = 2;               // synchroniser depth
  localparam int MSB_IDX     = WORD_W - 1;
  localparam logic signed [IN_W-1:0] IN_MIN  = 16'sh_E000;  // -8192
  localparam logic signed [IN_W-1:0] IN_MAX  = 16'sh_1FFF;  // +8191
  localparam logic [IN_W-1:0]        IN_BIAS = 16'h_2000;   // offset binary shift
  localparam logic [WORD_W-1:0]      WORD_RST = 14'h_0000;
endpackage

// >>> design/pas_stage.sv
// one pipelined quantiser stage with residue amplifier
// assumes capture_i is a one-cycle pulse on mclk_i
`timescale 1ns/1ps
`default_nettype none
module pas_stage #(
  parameter int BITS = 4
) (
  input  wire logic                      mclk_i,    // system clock
  input  wire logic                      sys_rst_i, // sync reset, high
  input  wire logic                      capture_i, // acquire phase ends
  input  wire logic [pas_pkg::WORD_W-1:0] res_i,    // residue in
  input  wire logic [pas_pkg::WORD_W-1:0] code_i,   // partial code in
  input  wire logic                      ovf_i,     // range flag in
  output logic      [pas_pkg::WORD_W-1:0] res_o,    // amplified residue
  output logic      [pas_pkg::WORD_W-1:0] code_o,   // code with own bits
  output logic                           ovf_o      // range flag out
);
  import pas_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] res;
    logic [WORD_W-1:0] code;
    logic              ovf;
  } pas_stage_t;

  pas_stage_t st_ff;
  pas_stage_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (capture_i) begin
      // quantise top bits, subtract them and amplify the rest
      nxt_st.code = (code_i << BITS) | WORD_W'(res_i[WORD_W-1 -: BITS]);
      nxt_st.res  = res_i << BITS;
      nxt_st.ovf  = ovf_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign res_o  = st_ff.res;
  assign code_o = st_ff.code;
  assign ovf_o  = st_ff.ovf;
endmodule
`default_nettype wire

// >>> dv/pas_top_assertions.sv
// port timing checks for the sample output block
// assumes bind to pas_top; strobe phases many mclk_i long
`timescale 1ns/1ps
`default_nettype none
module pas_top_assertions (
  input wire logic                  mclk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  sample_strobe_p_i,
  input wire logic                  sample_strobe_n_i,
  input wire logic                  output_drive_en_n_i,
  input wire logic [pas_pkg::WORD_W-1:0] sample_word_o,
  input wire logic                  sample_word_oe_o,
  input wire logic                  data_valid_strobe_o,
  input wire logic                  range_exceeded_flag_o
);
  wire s_hi = sample_strobe_p_i & ~sample_strobe_n_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_word_on_rise: assert property ($changed(sample_word_o) |-> $past(s_hi) && $past(s_hi, 2))
    else $error("word moved away from a strobe rise");
  a_dvs_fall_hi: assert property ($fell(data_valid_strobe_o) |-> $past(s_hi, 2))
    else $error("valid strobe fell without strobe high");
  a_dvs_rise_lo: assert property ($rose(data_valid_strobe_o) |-> !$past(s_hi, 2))
    else $error("valid strobe rose without strobe low");
  a_word_with_dvs: assert property ($changed(sample_word_o) |-> $fell(data_valid_strobe_o))
    else $error("word changed apart from valid strobe fall");
  a_flag_with_dvs: assert property ($changed(range_exceeded_flag_o) |-> $fell(data_valid_strobe_o))
    else $error("flag changed apart from valid strobe fall");
  a_oe_release: assert property (output_drive_en_n_i [*4] |=> !sample_word_oe_o)
    else $error("word pins still driven");
  a_oe_drive: assert property (!output_drive_en_n_i [*4] |=> sample_word_oe_o)
    else $error("word pins not driven");
  a_dvs_steady: assert property ($stable(s_hi) [*5] |-> $stable(data_valid_strobe_o))
    else $error("valid strobe moved without strobe edge");
  cover property ($fell(data_valid_strobe_o));
  cover property ($fell(sample_word_oe_o));
  cover property ($rose(range_exceeded_flag_o));
endmodule
`default_nettype wire

// >>> dv/pas_rx_model.sv
// receiving logic: keeps word and flag on each rising valid strobe from the sixth on
// assumes released word pins arrive as z
`timescale 1ns/1ps
`default_nettype none
module pas_rx_model (
  input  wire logic                  dvs_i,   // valid strobe
  input  wire logic [pas_pkg::WORD_W-1:0] word_i, // word pins
  input  wire logic                  flag_i,  // range flag
  output var logic  [pas_pkg::WORD_W-1:0] word_o, // kept word
  output var logic                   flag_o,  // kept flag
  output var int                     kept_o   // words kept
);
  int seen = 0;
  initial kept_o = 0;
  always @(posedge dvs_i) begin
    seen++;
    if (seen > 5) begin
      word_o = word_i;
      flag_o = flag_i;
      kept_o++;
    end
  end
endmodule
`default_nettype wire

// >>> dv/pas_top_tb_top.sv
// testbench for the sample output block
// assumes pas_pkg compiled first; strobe made here, 125 ns period
`timescale 1ns/1ps
`default_nettype none
module pas_top_tb_top;
  import pas_pkg::*;
  logic mclk_i = 0, sys_rst_i = 1, stb = 0, sel = 0, en_n = 0, oe, dvs, flag, rx_flag;
  logic signed [IN_W-1:0] lvl = '0;
  logic [WORD_W-1:0] word, rx_word;
  wire  [WORD_W-1:0] pins = oe ? word : 'z;
  int rx_kept, num_errors = 0, comparisons = 0, k = 0, lv_q[$];
  logic sel_q[$];
  always #5 mclk_i = ~mclk_i;
  pas_top dut (.mclk_i, .sys_rst_i, .sample_strobe_p_i(stb), .sample_strobe_n_i(!stb), .analog_level_i(lvl),
    .top_bit_flip_sel_i(sel), .output_drive_en_n_i(en_n), .sample_word_o(word), .sample_word_oe_o(oe),
    .data_valid_strobe_o(dvs), .range_exceeded_flag_o(flag));
  pas_rx_model rx (.dvs_i(dvs), .word_i(pins), .flag_i(flag), .word_o(rx_word), .flag_o(rx_flag), .kept_o(rx_kept));
  task automatic cmp(string what, logic [WORD_W-1:0] exp, logic [WORD_W-1:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic strobe(int v);
    logic [WORD_W-1:0] e;
    int l;
    stb = 0;
    lvl = v[IN_W-1:0];
    #61;
    if (rx_kept > k) begin
      l = lv_q[k];
      e = l < IN_MIN ? '0 : l > IN_MAX ? '1 : WORD_W'(l - int'(IN_MIN));
      e[MSB_IDX] = e[MSB_IDX] ^ !sel_q[k + 3];
      cmp("word", e, rx_word);
      cmp("flag", WORD_W'(l < IN_MIN || l > IN_MAX), WORD_W'(rx_flag));
      k++;
    end
    stb = 1;
    lv_q.push_back(v);
    sel_q.push_back(sel);
    #64;
  endtask
  task automatic t_codes(logic s);
    int tab[7] = '{-8192, 8191, -8193, 8192, 0, -1, 4660};
    sel = s;
    foreach (tab[i]) strobe(tab[i]);
    $display("codes done, select %0d", s);
  endtask
  task automatic t_drive;
    en_n = 1;
    #60;
    cmp("released pins", 'z, pins);
    en_n = 0;
    #60;
    cmp("driven oe", 1, WORD_W'(oe));
    $display("drive done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk_i);
    cmp("reset word", '0, word);
    cmp("reset oe dvs flag", 3'b100, WORD_W'({oe, dvs, flag}));
    $display("reset done");
    sys_rst_i = 0;
    @(posedge mclk_i);
    #3;
    t_codes(0);
    t_drive();
    t_codes(1);
    repeat (8) strobe(0);
    cmp("capture count", 1, WORD_W'(k >= 14));
    $display("flush done");
    tally_and_finish();
  end
endmodule
bind pas_top pas_top_assertions chk (.mclk_i, .sys_rst_i, .sample_strobe_p_i, .sample_strobe_n_i,
  .output_drive_en_n_i, .sample_word_o, .sample_word_oe_o, .data_valid_strobe_o, .range_exceeded_flag_o);
`default_nettype wire
